// ==== design/iatr_pkg.sv ====
// package: map, reset values and carrier types of the input alarm threshold registers
`default_nettype none
package iatr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [7:0] ADDR_FLAGS = 8'h20;
    localparam logic [7:0] ADDR_UPPER = 8'h24;
    localparam logic [7:0] ADDR_LOWER = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h34;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h38;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RST_UPPER = 16'hffff;
    localparam logic [7:0] RST_HYST = 8'h00;
    localparam logic [15:0] RST_LOWER = 16'h0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int FLAG_SUMMARY_BIT = 0;
    localparam int FLAG_HIGH_BIT = 4;
    localparam int FLAG_LOW_BIT = 5;
    localparam int IRQ_HIGH_BIT = 0;
    localparam int IRQ_LOW_BIT = 1;
    localparam int LIMIT_LSB = 0;
    localparam int HYST_LSB = 24;
    localparam int HYST_EFF_LSB = 2;
    localparam int PAD_BITS = 2;

    ////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic valid;
        logic [17:0] data;
    } iatr_conv_type;

    typedef struct packed {
        logic high;
        logic low;
        logic summary;
    } iatr_alarm_type;

    typedef struct packed {
        logic [15:0] upper;
        logic [7:0] hyst;
        logic [15:0] lower;
        logic high;
        logic low;
        logic summary;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic [31:0] prdata;
    } iatr_state_type;

    localparam iatr_state_type ST_RESET = '{
        upper: RST_UPPER,
        hyst: RST_HYST,
        lower: RST_LOWER,
        high: 1'b0,
        low: 1'b0,
        summary: 1'b0,
        irq_status: RST_IRQ,
        irq_enable: RST_IRQ,
        prdata: RST_RDATA
    };

endpackage
`default_nettype wire

// ==== design/iatr_regs.sv ====
// input alarm threshold registers: apb slave, limit compare with hysteresis, interrupt
// Notes on behaviour
// - upper limit and hysteresis word sits at 24h, bytes 24h to 27h
// - hysteresis lives in bits 31-24; upper six bits form the magnitude
// - upper compare value is the 16-bit field followed by two zeros
// - reset: upper FFFFh, hysteresis and lower zero, so only readings above 3FFFCh trip (high flag)
// - bits 23-16 of the upper word read zero and ignore writes
// - lower limit word sits at 28h, bytes 28h to 2Bh
// - lower compare value is the 16-bit field followed by two zeros
// - upper half of the lower word reads zero and ignores writes
// - separate read-only high and low trip flags, one while condition exists
// - summary bit is the OR of all trip flags
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module iatr_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iatr_pkg::iatr_conv_type conv,
    output iatr_pkg::iatr_alarm_type alarm,
    output logic irq
);

    iatr_pkg::iatr_state_type st_reg;
    iatr_pkg::iatr_state_type st_next;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [7:0] addr;
    logic access;
    logic wr;
    logic rd_setup;
    logic hit;
    logic wr_upper;
    logic wr_lower;
    logic wr_clear;
    logic wr_enable;

    assign addr = paddr[7:0];
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit = (addr == iatr_pkg::ADDR_FLAGS) | (addr == iatr_pkg::ADDR_UPPER)
        | (addr == iatr_pkg::ADDR_LOWER) | (addr == iatr_pkg::ADDR_IRQ_STATUS)
        | (addr == iatr_pkg::ADDR_IRQ_CLEAR) | (addr == iatr_pkg::ADDR_IRQ_ENABLE);
    assign wr_upper = wr & (addr == iatr_pkg::ADDR_UPPER);
    assign wr_lower = wr & (addr == iatr_pkg::ADDR_LOWER);
    assign wr_clear = wr & (addr == iatr_pkg::ADDR_IRQ_CLEAR);
    assign wr_enable = wr & (addr == iatr_pkg::ADDR_IRQ_ENABLE);

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~hit;

    ////////////////////////////////////////////////////////////////////////////
    // comparison values
    logic [17:0] upper18;
    logic [17:0] lower18;
    logic [17:0] hyst18;
    logic [18:0] data_plus_hyst;
    logic [18:0] lower_plus_hyst;

    assign upper18 = {st_reg.upper, {iatr_pkg::PAD_BITS{1'b0}}};
    assign lower18 = {st_reg.lower, {iatr_pkg::PAD_BITS{1'b0}}};
    // only the six upper hysteresis bits count, in the same scale as a limit
    assign hyst18 = {10'h000, st_reg.hyst[7:iatr_pkg::HYST_EFF_LSB],
        {iatr_pkg::PAD_BITS{1'b0}}};
    assign data_plus_hyst = {1'b0, conv.data} + {1'b0, hyst18};
    assign lower_plus_hyst = {1'b0, lower18} + {1'b0, hyst18};

    ////////////////////////////////////////////////////////////////////////////
    // next state
    logic high_next;
    logic low_next;
    logic [1:0] irq_set;

    always_comb begin
        st_next = st_reg;
        high_next = st_reg.high;
        low_next = st_reg.low;

        // whole word lands in one edge, so compares never see half a limit
        if (wr_upper) begin
            if (pstrb[0]) begin
                st_next.upper[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                st_next.upper[15:8] = pwdata[15:8];
            end
            // lane 2 has no storage
            if (pstrb[3]) begin
                st_next.hyst = pwdata[31:iatr_pkg::HYST_LSB];
            end
        end
        if (wr_lower) begin
            if (pstrb[0]) begin
                st_next.lower[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                st_next.lower[15:8] = pwdata[15:8];
            end
            // upper half has no storage
        end
        if (wr_enable && pstrb[0]) begin
            st_next.irq_enable = pwdata[1:0];
        end

        // alarm with hysteresis band
        if (conv.valid) begin
            if (conv.data > upper18) begin
                high_next = 1'b1;
            end else if (data_plus_hyst < {1'b0, upper18}) begin
                high_next = 1'b0;
            end
            if (conv.data < lower18) begin
                low_next = 1'b1;
            end else if ({1'b0, conv.data} > lower_plus_hyst) begin
                low_next = 1'b0;
            end
        end
        st_next.high = high_next;
        st_next.low = low_next;
        st_next.summary = high_next | low_next;

        // sticky trip events; a new event wins over a clear in the same cycle
        irq_set = 2'b00;
        irq_set[iatr_pkg::IRQ_HIGH_BIT] = high_next & ~st_reg.high;
        irq_set[iatr_pkg::IRQ_LOW_BIT] = low_next & ~st_reg.low;
        if (wr_clear && pstrb[0]) begin
            st_next.irq_status = st_reg.irq_status & ~pwdata[1:0];
        end
        st_next.irq_status = st_next.irq_status | irq_set;

        // read data captured in the setup phase, held through the access
        if (rd_setup) begin
            st_next.prdata = 32'h0000_0000;
            case (addr)
                iatr_pkg::ADDR_FLAGS: begin
                    st_next.prdata[iatr_pkg::FLAG_HIGH_BIT] = st_reg.high;
                    st_next.prdata[iatr_pkg::FLAG_LOW_BIT] = st_reg.low;
                    st_next.prdata[iatr_pkg::FLAG_SUMMARY_BIT] = st_reg.summary;
                end
                iatr_pkg::ADDR_UPPER: begin
                    st_next.prdata[15:0] = st_reg.upper;
                    st_next.prdata[31:iatr_pkg::HYST_LSB] = st_reg.hyst;
                end
                iatr_pkg::ADDR_LOWER: begin
                    st_next.prdata[15:0] = st_reg.lower;
                end
                iatr_pkg::ADDR_IRQ_STATUS: begin
                    st_next.prdata[1:0] = st_reg.irq_status;
                end
                iatr_pkg::ADDR_IRQ_ENABLE: begin
                    st_next.prdata[1:0] = st_reg.irq_enable;
                end
                default: begin
                    st_next.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= iatr_pkg::ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign alarm = '{high: st_reg.high, low: st_reg.low, summary: st_reg.summary};
    assign irq = |(st_reg.irq_status & st_reg.irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_upper_write;
        wr_upper && pstrb[1:0] == 2'b11 |=> st_reg.upper == $past(pwdata[15:0]);
    endproperty
    a_upper_write: assert property (p_upper_write)
        else $error("upper limit not taken from write");

    property p_hyst_write;
        wr_upper && pstrb[3] |=> st_reg.hyst == $past(pwdata[31:24]);
    endproperty
    a_hyst_write: assert property (p_hyst_write)
        else $error("hysteresis byte not taken from write");

    property p_reset_values;
        $fell(sys_rst) |-> st_reg.upper == 16'hffff && st_reg.hyst == 8'h00
            && st_reg.lower == 16'h0000 && !st_reg.high && !st_reg.low;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong values after reset");

    property p_upper_read;
        rd_setup && addr == 8'h24 |=> prdata[23:16] == 8'h00
            && prdata[15:0] == $past(st_reg.upper) && prdata[31:24] == $past(st_reg.hyst);
    endproperty
    a_upper_read: assert property (p_upper_read)
        else $error("upper word read back wrong");

    property p_lower_write;
        wr_lower && pstrb[1:0] == 2'b11 |=> st_reg.lower == $past(pwdata[15:0]);
    endproperty
    a_lower_write: assert property (p_lower_write)
        else $error("lower limit not taken from write");

    property p_lower_read;
        rd_setup && addr == 8'h28 |=> prdata[31:16] == 16'h0000
            && prdata[15:0] == $past(st_reg.lower);
    endproperty
    a_lower_read: assert property (p_lower_read)
        else $error("lower word read back wrong");

    property p_high_trip;
        conv.valid && conv.data > {st_reg.upper, 2'b00} |=> alarm.high;
    endproperty
    a_high_trip: assert property (p_high_trip)
        else $error("high alarm missed");

    property p_low_trip;
        conv.valid && conv.data < {st_reg.lower, 2'b00} |=> alarm.low;
    endproperty
    a_low_trip: assert property (p_low_trip)
        else $error("low alarm missed");

    property p_high_hold;
        alarm.high && conv.valid && data_plus_hyst >= {1'b0, upper18} |=> alarm.high;
    endproperty
    a_high_hold: assert property (p_high_hold)
        else $error("high alarm released inside band");

    property p_summary;
        alarm.summary == (alarm.high | alarm.low);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary differs from flags");

    property p_flag_read;
        rd_setup && addr == 8'h20 |=> prdata[4] == $past(st_reg.high)
            && prdata[5] == $past(st_reg.low);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("trip flags read back wrong");

    property p_low_hold;
        alarm.low && conv.valid && {1'b0, conv.data} <= lower_plus_hyst |=> alarm.low;
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low alarm released inside band");

    property p_high_release;
        alarm.high && conv.valid && conv.data <= upper18
            && {1'b0, conv.data} + {1'b0, hyst18} < {1'b0, upper18} |=> !alarm.high;
    endproperty
    a_high_release: assert property (p_high_release)
        else $error("high alarm held past band");

    property p_low_release;
        alarm.low && conv.valid && conv.data >= lower18
            && {1'b0, conv.data} > {1'b0, lower18} + {1'b0, hyst18} |=> !alarm.low;
    endproperty
    a_low_release: assert property (p_low_release)
        else $error("low alarm held past band");

    property p_lane_keep;
        wr_upper && pstrb[3:1] == 3'b000 |=> st_reg.upper[15:8] == $past(st_reg.upper[15:8])
            && st_reg.hyst == $past(st_reg.hyst);
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("upper word byte changed without its strobe");

    property p_trip_event;
        conv.valid && conv.data > upper18 && !alarm.high |=> st_reg.irq_status[0];
    endproperty
    a_trip_event: assert property (p_trip_event)
        else $error("high trip event not recorded");

    c_high: cover property (!alarm.high ##1 alarm.high);
    c_low_release: cover property (alarm.low ##1 !alarm.low);
    c_low: cover property (!alarm.low ##1 alarm.low);
    c_irq: cover property (!irq ##1 irq);
    c_err: cover property (pslverr);

endmodule
`default_nettype wire

// ==== test/iatr_host.sv ====
// host model: apb master that reaches the alarm threshold register bank
`default_nettype none
module iatr_host (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rd;
    logic err;
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // setup, then access held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // released data must not keep showing the last value
        pwdata <= ~d;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ==== test/iatr_regs_bench.sv ====
// bench: register map, reset values, alarm compare with hysteresis, interrupt
`default_nettype none
module iatr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] e;
        logic x;
    } iatr_row_type;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    iatr_pkg::iatr_conv_type conv;
    iatr_pkg::iatr_alarm_type alarm;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    iatr_row_type rows [10] = '{
        '{1'h1, 8'h24, 32'hfcaa_1234, 4'hf, 32'h0000_0000, 1'h0},
        '{1'h0, 8'h24, 32'h0000_0000, 4'h0, 32'hfc00_1234, 1'h0},
        '{1'h1, 8'h24, 32'h0000_0056, 4'h1, 32'h0000_0000, 1'h0},
        '{1'h0, 8'h24, 32'h0000_0000, 4'h0, 32'hfc00_1256, 1'h0},
        '{1'h1, 8'h28, 32'hffff_0100, 4'hf, 32'h0000_0000, 1'h0},
        '{1'h0, 8'h28, 32'h0000_0000, 4'h0, 32'h0000_0100, 1'h0},
        '{1'h1, 8'h38, 32'h0000_0003, 4'h1, 32'h0000_0000, 1'h0},
        '{1'h0, 8'h38, 32'h0000_0000, 4'h0, 32'h0000_0003, 1'h0},
        '{1'h0, 8'h3c, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'h1},
        '{1'h1, 8'h3c, 32'h0000_1234, 4'hf, 32'h0000_0000, 1'h1}
    };
    iatr_regs #(.ADDR_W(8)) iatr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv(conv),
        .alarm(alarm), .irq(irq));
    iatr_host iatr_host_i (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        iatr_host_i.xfer(1'h1, a, d, s);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        iatr_host_i.xfer(1'h0, a, 32'h0000_0000, 4'h0);
        chk(iatr_host_i.rd, e);
    endtask
    // one conversion pulse; alarms land at the taking edge and are looked at one edge later
    task automatic cv(input logic [17:0] v, input logic [2:0] e);
        conv <= '{valid: 1'h1, data: v};
        @(posedge core_clk);
        conv <= '{valid: 1'h0, data: ~v};
        @(posedge core_clk);
        chk({29'h0, alarm}, {29'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        sys_rst = 1'h1;
        conv = '{valid: 1'h0, data: 18'h0_0000};
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            iatr_host_i.xfer(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
            chk({31'h0, iatr_host_i.err}, {31'h0, rows[i].x});
            if (!rows[i].w) chk(iatr_host_i.rd, rows[i].e);
        end
        // second reset in mid-run brings back the safe limits
        sys_rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(posedge core_clk);
        rd(8'h24, 32'h0000_ffff);
        rd(8'h28, 32'h0000_0000);
        rd(8'h38, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        cv(18'h3_fffc, 3'h0);
        cv(18'h0_0000, 3'h0);
        // upper 400h with band fch, lower 100h; host keeps hysteresis bits 1:0 at zero
        wr(8'h24, 32'hfc00_0100, 4'hf);
        wr(8'h28, 32'h0000_0040, 4'hf);
        wr(8'h38, 32'h0000_0003, 4'h1);
        cv(18'h0_0400, 3'h0);
        cv(18'h0_0401, 3'h5);
        chk({31'h0, irq}, 32'h0000_0001);
        cv(18'h0_0304, 3'h5);
        cv(18'h0_0303, 3'h0);
        rd(8'h30, 32'h0000_0001);
        rd(8'h20, 32'h0000_0000);
        wr(8'h34, 32'h0000_0001, 4'h1);
        chk({31'h0, irq}, 32'h0000_0000);
        cv(18'h0_00ff, 3'h3);
        rd(8'h20, 32'h0000_0021);
        cv(18'h0_01fc, 3'h3);
        cv(18'h0_01fd, 3'h0);
        wr(8'h38, 32'h0000_0000, 4'h1);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(8'h38, 32'h0000_0002, 4'h1);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(8'h34, 32'h0000_0002, 4'h1);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
